// *** rtl/od_io_defs.vh ***
/*
 open-drain io structure constants: group sizes, select and reset values.
 assumes inclusion by bare name from the rtl files.
*/
`ifndef OD_IO_DEFS_VH
`define OD_IO_DEFS_VH
`define WAND_CELLS 4
`define WOR_CELLS 4
`define MUX_CELLS 4
`define MUX_SEL_W 2
`define FLOAT_ON 1'h1
`define FLOAT_OFF 1'h0
`define RST_FLOAT 1'h1
`define RST_DATA 1'h0
`define STATE_IDLE 2'h1
`define STATE_DRIVE 2'h2
`endif

// *** rtl/io_cell.v ***
/*
 one three-state pad cell, registered: data and float control sampled together
 so both leave flip-flops on one edge. assumes the pad level is resolved outside.
*/
`timescale 1ns/100ps
`include "od_io_defs.vh"
module io_cell (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire next_data,
	input wire next_float,
	output reg pad_o,
	output reg pad_oe
);
	// equal register paths keep data and float skew small
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pad_o <= `RST_DATA;
			pad_oe <= ~`RST_FLOAT;
		end else if (ce) begin
			pad_o <= next_data;
			pad_oe <= ~next_float;
		end
	end
endmodule // io_cell

// *** rtl/open_drain_io_structures.v ***
/*
 open-drain output, wired-and, wired-or, shared-line multiplexer and
 resistor-assisted hysteresis input built from three-state pad cells.
 assumes external pull-ups on shared lines and resistor dividers at the sense pad;
 pad enables are high while driving and leave a flip-flop in each cell.
 ce low freezes every flop, pad cells included.
 a select change on the multiplexer costs one cycle with all sources released.
 sense feedback follows the raw synchronised level, never the inverted one.
*/
`timescale 1ns/100ps
`include "od_io_defs.vh"
//
// Behaviour
// - float high releases pad, low drives data
// - open drain ties data and float together
// - high signal floats pad, pull-up raises
// - low signal drives pad low directly
// - keep data and float skew small
// - wired-and true inputs float their pads
// - wired-and false input drives line low
// - wired-or is negative-logic wired-and
// - mux source selected by float low
// - mux never enables two drivers
// - inverted sense feeds high-drive cell float
// - sense low: low cell drives, high floats
// - sense high: low floats, high drives high
// - inverting variant flips sensed signal sense
module open_drain_io_structures (
	input wire mclk,
	input wire rst,
	input wire ce,
	input wire od_sig,
	output wire od_pad_o,
	output wire od_pad_oe,
	input wire [`WAND_CELLS-1:0] wand_in,
	output wire [`WAND_CELLS-1:0] wand_pad_o,
	output wire [`WAND_CELLS-1:0] wand_pad_oe,
	input wire [`WOR_CELLS-1:0] wor_req_n,
	output wire [`WOR_CELLS-1:0] wor_pad_o,
	output wire [`WOR_CELLS-1:0] wor_pad_oe,
	input wire [`MUX_CELLS-1:0] mux_src,
	input wire mux_en,
	input wire [`MUX_SEL_W-1:0] mux_sel,
	output wire [`MUX_CELLS-1:0] mux_pad_o,
	output wire [`MUX_CELLS-1:0] mux_pad_oe,
	input wire sense_pad_i,
	input wire invert_sense,
	output wire low_drive_o,
	output wire low_drive_oe,
	output wire high_drive_o,
	output wire high_drive_oe,
	output reg sensed
);
	wire [`MUX_CELLS-1:0] mux_pick;
	wire fb_level;
	// synchroniser stages and filtered raw level
	reg sync_a;
	reg sync_b;
	reg sync_c;
	reg settled;
	reg next_settled;
	// multiplexer state
	reg [1:0] mux_state;
	reg [1:0] next_mux_state;
	reg [`MUX_SEL_W-1:0] cur_sel;
	reg [`MUX_SEL_W-1:0] next_cur_sel;
	reg next_sensed;
	genvar i;

	//////////////////////////////////////////////////////////////////////////////
	// single open-drain output
	io_cell u_od (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.next_data(od_sig),
		.next_float(od_sig),
		.pad_o(od_pad_o),
		.pad_oe(od_pad_oe)
	);

	//////////////////////////////////////////////////////////////////////////////
	// wired-and and wired-or groups
	// true input releases its pad, false input pulls the line low
	generate
		for (i = 0; i < `WAND_CELLS; i = i + 1) begin : g_wand
			io_cell u_cell (
				.mclk(mclk),
				.rst(rst),
				.ce(ce),
				.next_data(wand_in[i]),
				.next_float(wand_in[i]),
				.pad_o(wand_pad_o[i]),
				.pad_oe(wand_pad_oe[i])
			);
		end

		for (i = 0; i < `WOR_CELLS; i = i + 1) begin : g_wor
			// active-low request pulls shared line low
			io_cell u_cell (
				.mclk(mclk),
				.rst(rst),
				.ce(ce),
				.next_data(wor_req_n[i]),
				.next_float(wor_req_n[i]),
				.pad_o(wor_pad_o[i]),
				.pad_oe(wor_pad_oe[i])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// shared-line multiplexer: a select change passes through idle first
	localparam [1:0] MUX_IDLE = `STATE_IDLE;
	localparam [1:0] MUX_DRIVE = `STATE_DRIVE;

	always @* begin
		next_mux_state = mux_state;
		next_cur_sel = cur_sel;
		case (mux_state)
			MUX_IDLE: begin
				// take a select only while no source drives
				if (mux_en) begin
					next_cur_sel = mux_sel;
					next_mux_state = MUX_DRIVE;
				end
			end
			MUX_DRIVE: begin
				// break before make on any select change
				if (!mux_en || mux_sel != cur_sel) begin
					next_mux_state = MUX_IDLE;
				end
			end
			default: begin
				next_mux_state = MUX_IDLE;
			end
		endcase
	end

	// select and state move together, frozen while ce is low
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			mux_state <= MUX_IDLE;
			cur_sel <= {`MUX_SEL_W{1'b0}};
		end else if (ce) begin
			mux_state <= next_mux_state;
			cur_sel <= next_cur_sel;
		end
	end

	// one-hot pick of the source that drives after this edge
	assign mux_pick = {{(`MUX_CELLS-1){1'b0}}, 1'b1} << next_cur_sel;

	// registered float: a released cell never glitches onto the line
	generate
		for (i = 0; i < `MUX_CELLS; i = i + 1) begin : g_mux
			io_cell u_cell (
				.mclk(mclk),
				.rst(rst),
				.ce(ce),
				.next_data(mux_src[i]),
				.next_float(!((next_mux_state == MUX_DRIVE)
					&& mux_pick[i])),
				.pad_o(mux_pad_o[i]),
				.pad_oe(mux_pad_oe[i])
			);
		end
	endgenerate

	//////////////////////////////////////////////////////////////////////////////
	// hysteresis input: sense pad synchronised, feedback drives the divider
	// three stages: a change counts once the second and third agree
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			sync_c <= 1'b0;
			settled <= 1'b0;
			sensed <= 1'b0;
		end else if (ce) begin
			sync_a <= sense_pad_i;
			sync_b <= sync_a;
			sync_c <= sync_b;
			settled <= next_settled;
			sensed <= next_sensed;
		end
	end

	// settled keeps the raw level, so a change of invert_sense
	// never disturbs the feedback while the stages disagree
	always @* begin
		next_settled = settled;
		if (sync_b == sync_c) begin
			next_settled = sync_c;
		end
		next_sensed = next_settled ^ invert_sense;
	end

	// raw level before optional inversion drives the feedback
	assign fb_level = next_settled;

	// low-drive cell pulls the divider down while the raw level is low
	io_cell u_low (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.next_data(1'b0),
		.next_float(fb_level),
		.pad_o(low_drive_o),
		.pad_oe(low_drive_oe)
	);

	// high-drive cell reinforces a high raw level through its resistor
	io_cell u_high (
		.mclk(mclk),
		.rst(rst),
		.ce(ce),
		.next_data(1'b1),
		.next_float(~fb_level),
		.pad_o(high_drive_o),
		.pad_oe(high_drive_oe)
	);
endmodule // open_drain_io_structures

// *** tb/pulled_line.sv ***
/* shared line with pull-up: resolves all cells' drives. assumes oe high = driving. */
`timescale 1ns/100ps
module pulled_line #(parameter int N = 4) (
	input logic [N-1:0] o,
	input logic [N-1:0] oe,
	output logic lvl,
	output logic clash
);
	// any low driver wins, released line goes high
	assign lvl = |(oe & ~o) ? 1'h0 : 1'h1;
	assign clash = |(oe & ~o) && |(oe & o);
endmodule // pulled_line

// *** tb/od_io_props.sv ***
/* pad enable checks of the io structures. bound to the top module. */
`timescale 1ns/100ps
module od_io_props (
	input logic mclk, rst, ce, od_sig, od_pad_o, od_pad_oe,
	input logic [3:0] wand_in, wand_pad_oe, wor_req_n, wor_pad_oe, mux_pad_oe,
	input logic [1:0] mux_sel,
	input logic low_drive_o, low_drive_oe, high_drive_o, high_drive_oe, sensed, invert_sense
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence took;
		$past(ce) && !$past(rst);
	endsequence
	od_drive_a: assert property (took ##0 !$past(od_sig) |-> od_pad_oe && !od_pad_o)
		else $error("od drive");
	od_float_a: assert property (took ##0 $past(od_sig) |-> !od_pad_oe)
		else $error("od float");
	wand_oe_a: assert property (took |-> wand_pad_oe == ~$past(wand_in))
		else $error("wand oe");
	wor_oe_a: assert property (took |-> wor_pad_oe == ~$past(wor_req_n))
		else $error("wor oe");
	mux_one_a: assert property ($onehot0(mux_pad_oe))
		else $error("mux two");
	mux_gap_a: assert property (|mux_pad_oe && |$past(mux_pad_oe) |-> $stable(mux_pad_oe))
		else $error("mux gap");
	mux_sel_a: assert property (took ##0 |mux_pad_oe |->
		mux_pad_oe == 4'h1 << $past(mux_sel))
		else $error("mux sel");
	hyst_hi_a: assert property (high_drive_oe |-> high_drive_o && !low_drive_oe)
		else $error("hyst hi");
	hyst_lo_a: assert property (low_drive_oe |-> !low_drive_o && !high_drive_oe)
		else $error("hyst lo");
	hyst_fb_a: assert property (took |->
		high_drive_oe == (sensed ^ $past(invert_sense)))
		else $error("hyst fb");
	hyst_one_a: assert property (took |-> low_drive_oe != high_drive_oe)
		else $error("hyst one");
endmodule // od_io_props
bind open_drain_io_structures od_io_props chk (.*);

// *** tb/open_drain_io_structures_tb_top.sv ***
/* testbench: drives every structure, judges resolved lines. assumes pulled_line. */
`timescale 1ns/100ps
module open_drain_io_structures_tb_top;
	logic mclk = 0, rst = 1, ce = 1, od_sig = 1, mux_en = 0, sense_pad_i = 0, invert_sense = 0;
	logic [3:0] wand_in = 4'hF, wor_req_n = 4'hF, mux_src = 4'h5;
	logic [1:0] mux_sel = 2'h0;
	wire od_pad_o, od_pad_oe, low_drive_o, low_drive_oe, high_drive_o, high_drive_oe, sensed;
	wire [3:0] wand_pad_o, wand_pad_oe, wor_pad_o, wor_pad_oe, mux_pad_o, mux_pad_oe;
	wire od_l, wand_l, wor_l, mux_l, mux_c;
	int num_errors = 0, samples_checked = 0;
	always #4 mclk = ~mclk;
	open_drain_io_structures dut (.*);
	pulled_line #(1) od_m (.o(od_pad_o), .oe(od_pad_oe), .lvl(od_l), .clash());
	pulled_line wa_m (.o(wand_pad_o), .oe(wand_pad_oe), .lvl(wand_l), .clash());
	pulled_line wo_m (.o(wor_pad_o), .oe(wor_pad_oe), .lvl(wor_l), .clash());
	pulled_line mx_m (.o(mux_pad_o), .oe(mux_pad_oe), .lvl(mux_l), .clash(mux_c));
	task step(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task chk(string nm, logic e, logic g);
		samples_checked++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %b got %b", nm, e, g);
		end
	endtask
	task t_od;
		for (int v = 0; v < 2; v++) begin
			od_sig = v[0];
			step(1);
			chk("od", v[0], od_l);
		end
		ce = 0;
		od_sig = 0;
		step(2);
		chk("od hold", 1'h1, od_l);
		ce = 1;
	endtask
	task t_wired;
		for (int i = 0; i < 16; i++) begin
			wand_in = i[3:0];
			wor_req_n = i[3:0];
			step(1);
			chk("wand", &i[3:0], wand_l);
			chk("wor", &i[3:0], wor_l);
		end
	endtask
	task t_mux;
		mux_en = 1;
		for (int s = 0; s < 4; s++) begin
			mux_sel = s[1:0];
			step(2);
			chk("mux", mux_src[s], mux_l);
			mux_src = ~mux_src;
			step(2);
			chk("mux", mux_src[s], mux_l);
			chk("clash", 1'h0, mux_c);
		end
		mux_en = 0;
	endtask
	task t_sense;
		sense_pad_i = 1;
		step(6);
		chk("sensed", 1'h1, sensed);
		chk("hi", 1'h1, high_drive_oe & high_drive_o);
		invert_sense = 1;
		step(6);
		chk("sensed", 1'h0, sensed);
		chk("hi raw", 1'h1, high_drive_oe);
		sense_pad_i = 0;
		step(6);
		chk("sensed", 1'h1, sensed);
		chk("lo", 1'h1, low_drive_oe);
		chk("lo drv", 1'h0, low_drive_o);
	endtask
	task final_report;
		$display("errors %0d checks %0d", num_errors, samples_checked);
		if (num_errors == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		final_report;
	end
	initial begin
		step(2);
		rst = 0;
		step(1);
		t_od;
		t_wired;
		t_mux;
		t_sense;
		final_report;
	end
endmodule // open_drain_io_structures_tb_top
